// ==== inc/spfpr_pkg.sv ====
`default_nettype none
package spfpr_pkg;
   // one-byte command codes, first byte after select falls
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_STATUS_READ = 8'h05;
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_FAST_READ = 8'h0B;
   localparam logic [7:0] CMD_BULK_ERASE = 8'hC7;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
   // status byte field positions
   localparam int BIT_BUSY = 0;
   localparam int BIT_LATCH = 1;
   localparam int BIT_PROT_LO = 2;
   localparam int BIT_PROT_HI = 4;
   localparam int BIT_SWD = 7;
   // array geometry: 22 used address bits, 64 sectors
   localparam int ADDR_W = 22;
   localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
   localparam logic [6:0] SECTOR_COUNT = 7'h40;
   // values after reset (delivery state of the non-volatile bits)
   localparam logic [2:0] PROT_RST = 3'h0;
   localparam logic SWD_RST = 1'h0;
   localparam logic LATCH_RST = 1'h0;
   // self-timed status write duration
   localparam int T_W_US = 15000;
   localparam int CLK_MHZ = 10;
   localparam int T_W_CYC = T_W_US * CLK_MHZ;
   // array operation kinds handed to the array controller
   localparam logic [1:0] OP_PROGRAM = 2'h1;
   localparam logic [1:0] OP_SECTOR = 2'h2;
   localparam logic [1:0] OP_BULK = 2'h3;
   typedef enum logic [3:0] {
      ST_CMD,
      ST_ADDR,
      ST_DUMMY,
      ST_SW_DATA,
      ST_PROG_DATA,
      ST_CMD_END,
      ST_READ,
      ST_STAT,
      ST_IGNORE
   } spfpr_state_t;
endpackage : spfpr_pkg
`default_nettype wire

// ==== verif/spfpr_host.sv ====
`default_nettype none
// spi host: mode 0, select and data move only at falling system edges
module spfpr_host (
   input wire logic clk_in,
   input wire logic q_in,
   output logic cs_n_out,
   output logic sclk_out,
   output logic sdi_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle: deselected, serial clock resting low
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end

   task automatic sel();
      @(negedge clk_in);
      cs_n_out <= 1'b0;
   endtask : sel

   // gap after deselect covers the device's select synchroniser
   task automatic desel();
      @(negedge clk_in);
      cs_n_out <= 1'b1;
      sdi_out <= ~sdi_out; // released line must not keep a stale value
      repeat (5) @(negedge clk_in);
   endtask : desel

   // n bits msb first; 5 clk low, 3 clk high gives the 800 ns period
   task automatic shift8(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i >= 8 - n; i--) begin
         sdi_out <= tx[i];
         repeat (4) @(negedge clk_in);
         rx[i] = q_in; // sampled late in low half, after the device shifted
         @(negedge clk_in);
         sclk_out <= 1'b1;
         repeat (3) @(negedge clk_in);
         sclk_out <= 1'b0;
      end
   endtask : shift8
endmodule : spfpr_host
`default_nettype wire

// ==== verif/tb_spfpr_core.sv ====
`default_nettype none
module tb_spfpr_core;
   import spfpr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic wp_pin = 1'b1;
   logic q;
   logic q_oe_n;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] mem_data = 8'h00;
   logic op_start;
   logic [1:0] op_kind;
   logic op_busy = 1'b0;
   logic [7:0] status;
   logic prot_mode;
   logic [ADDR_W-1:0] op_addr;
   int fails = 0;
   int checks_done = 0;
   int ops = 0;
   int busy_cnt = 0;
   logic [7:0] rx;

   always #50 clk = ~clk;

   spfpr_host i_host (.clk_in(clk), .q_in(q), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi));

   // short timed cycle; a status read and a refused read frame still fit inside it
   spfpr_core #(.T_W_CYCLES(600)) i_dut (
      .clk_in(clk), .nrst_in(nrst), .cs_n_in(cs_n), .sclk_in(sclk), .serial_data_in(sdi),
      .write_protect_pin_in(wp_pin), .q_out(q), .q_oe_n_out(q_oe_n), .mem_addr_out(mem_addr),
      .mem_data_in(mem_data), .op_start_out(op_start), .op_kind_out(op_kind), .op_addr_out(op_addr),
      .op_busy_in(op_busy), .status_out(status), .hardware_protected_mode_out(prot_mode));

   function automatic logic [7:0] pat(input logic [ADDR_W-1:0] a);
      return a[7:0] ^ {2'h0, a[21:16]};
   endfunction : pat

   // array model: data follows address, each accepted op keeps busy 50 clk
   always @(negedge clk) begin
      mem_data <= pat(mem_addr);
      if (op_start === 1'b1) begin
         ops <= ops + 1;
         busy_cnt <= 50;
      end else if (busy_cnt > 0) begin
         busy_cnt <= busy_cnt - 1;
      end
      op_busy <= (busy_cnt > 1) || (op_start === 1'b1);
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic cmd(input logic [7:0] code);
      i_host.sel();
      i_host.shift8(code, 8, rx);
      i_host.desel();
   endtask : cmd

   task automatic swrite(input logic [7:0] val, input int n);
      i_host.sel();
      i_host.shift8(CMD_STATUS_WRITE, 8, rx);
      i_host.shift8(val, n, rx);
      i_host.desel();
   endtask : swrite

   task automatic erase_at(input logic [23:0] addr);
      i_host.sel();
      i_host.shift8(CMD_SECTOR_ERASE, 8, rx);
      for (int b = 2; b >= 0; b--) i_host.shift8(addr[b*8 +: 8], 8, rx);
      i_host.desel();
   endtask : erase_at

   // bounded wait for the busy flag to drop
   task automatic wait_idle();
      for (int i = 0; i < 1000 && status[BIT_BUSY] !== 1'b0; i++) @(negedge clk);
      check(status[BIT_BUSY], 1'b0, "busy stuck");
   endtask : wait_idle

   task automatic read_at(input logic [7:0] code, input logic [23:0] addr, input int n);
      logic [ADDR_W-1:0] a;
      i_host.sel();
      i_host.shift8(code, 8, rx);
      for (int b = 2; b >= 0; b--) i_host.shift8(addr[b*8 +: 8], 8, rx);
      if (code == CMD_FAST_READ) i_host.shift8(8'h00, 8, rx);
      for (int k = 0; k < n; k++) begin
         a = addr[ADDR_W-1:0] + ADDR_W'(k);
         i_host.shift8(8'h00, 8, rx);
         check(rx, pat(a), "read byte");
         check(q_oe_n, 1'b0, "output enable");
      end
      i_host.desel();
      check(q_oe_n, 1'b1, "output after select rise");
      $display("read %h code %h done", addr, code);
   endtask : read_at

   task automatic t_status();
      check(status, 8'h00, "status after reset");
      swrite(8'hFF, 8);
      repeat (6) @(negedge clk);
      check(status, 8'h00, "write without latch");
      cmd(CMD_WRITE_ENABLE);
      check(status, 8'h02, "latch set");
      cmd(CMD_WRITE_DISABLE);
      check(status, 8'h00, "latch reset");
      cmd(CMD_WRITE_ENABLE);
      swrite(8'hFF, 7);
      repeat (6) @(negedge clk);
      check(status, 8'h02, "short write discarded");
      swrite(8'hFF, 8);
      check(status[BIT_BUSY], 1'b1, "busy in cycle");
      i_host.sel();
      i_host.shift8(CMD_STATUS_READ, 8, rx);
      i_host.shift8(8'h00, 8, rx);
      i_host.desel();
      check(rx, 8'h03, "status read in cycle");
      i_host.sel();
      for (int b = 0; b < 5; b++) i_host.shift8(b == 0 ? CMD_READ : 8'h00, 8, rx);
      check(q_oe_n, 1'b1, "read refused while busy");
      check(status[BIT_BUSY], 1'b1, "cycle continues");
      i_host.desel();
      wait_idle();
      check(status, 8'h9C, "status after write");
      $display("status write test done");
   endtask : t_status

   task automatic t_protect();
      wp_pin <= 1'b0;
      repeat (6) @(negedge clk);
      check(prot_mode, 1'b1, "protected mode entered");
      cmd(CMD_WRITE_ENABLE);
      cmd(CMD_BULK_ERASE);
      erase_at(24'h00_0000);
      check(ops, 0, "erase into protected area");
      swrite(8'h00, 8);
      repeat (6) @(negedge clk);
      check(status, 8'h9E, "write in protected mode");
      wp_pin <= 1'b1;
      repeat (6) @(negedge clk);
      check(prot_mode, 1'b0, "protected mode left");
      swrite(8'h00, 8);
      wait_idle();
      check(status, 8'h00, "write with pin high");
      wp_pin <= 1'b0;
      cmd(CMD_WRITE_ENABLE);
      swrite(8'h0C, 8);
      wait_idle();
      check(status, 8'h0C, "write with pin low, bit clear");
      wp_pin <= 1'b1;
      swrite(8'h00, 8);
      check(status, 8'h0C, "write after latch cleared");
      cmd(CMD_WRITE_ENABLE);
      cmd(CMD_BULK_ERASE);
      check(ops, 0, "bulk erase with protect set");
      erase_at(24'h3F_0000);
      check(ops, 0, "sector erase into top sector");
      erase_at(24'hC1_0000);
      check(ops, 1, "sector erase outside region");
      check(op_kind, OP_SECTOR, "sector erase kind");
      check(op_addr, 22'h01_0000, "sector erase address");
      cmd(CMD_WRITE_ENABLE);
      swrite(8'h00, 8);
      wait_idle();
      cmd(CMD_WRITE_ENABLE);
      cmd(CMD_BULK_ERASE);
      check(ops, 2, "bulk erase accepted");
      check(op_kind, OP_BULK, "bulk erase kind");
      $display("protection test done");
   endtask : t_protect

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   // a full run needs under 1 ms of frames; three times that means a hang
   initial begin
      #3ms;
      fails++;
      close_out();
   end

   initial begin
      repeat (16) @(negedge clk);
      nrst <= 1'b1;
      repeat (4) @(negedge clk);
      read_at(CMD_READ, 24'hC0_0010, 3);
      read_at(CMD_FAST_READ, 24'h3F_FFFF, 2);
      t_status();
      t_protect();
      close_out();
   end
endmodule : tb_spfpr_core
`default_nettype wire

// ==== verilog/spfpr_core.sv ====
`default_nettype none
// Overview of operation
// - protect-size bits persist and change only via status write command; reset also reloads them with PROT_RST.
// - program or sector erase into the protected region is refused.
// - bulk erase runs only when all protect-size bits are zero.
// - hardware-protected mode makes protect bits read-only and rejects status writes.
// - status write needs write-enable latch set beforehand; host sends write-enable first.
// - status write leaves b6,b5,b1,b0 alone; b6,b5 read zero.
// - select must rise right after eighth data bit, else write discarded.
// - valid status write starts timed cycle; busy flag high throughout; status readable.
// - write-enable latch clears when the status write cycle completes.
// - disable bit zero allows writes any pin level; one needs pin high.
// - hardware-protected mode rejects status writes even with latch set.
// - protected mode entered by bit set with pin low, or pin low later.
// - only raising the write-protect pin leaves hardware-protected mode; reset also leaves it by loading SWD_RST.
// - read is command plus three address bytes, bits taken on clock rise.
// - read data leaves msb first, one bit per falling clock edge.
// - address increments after each byte and wraps to zero.
// - select rising ends a read and output stops driving.
// - reads rejected while any write cycle runs; cycle continues unaffected.
// - fast read has one dummy byte before data output.
// - top two address bits are ignored.
// - codes 01h status write, 03h read, 0Bh fast read, sent first.
// - write-enable command 06h sets the write-enable latch.
// - busy flag is one while status write, program or erase runs.
// - latch at zero blocks status write, program and erase.
module spfpr_core
   import spfpr_pkg::*;
#(
   parameter int unsigned T_W_CYCLES = T_W_CYC
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic serial_data_in,
   input wire logic write_protect_pin_in,
   output logic q_out,
   output logic q_oe_n_out,
   output logic [ADDR_W-1:0] mem_addr_out,
   input wire logic [7:0] mem_data_in,
   output logic op_start_out,
   output logic [1:0] op_kind_out,
   output logic [ADDR_W-1:0] op_addr_out,
   input wire logic op_busy_in,
   output logic [7:0] status_out,
   output logic hardware_protected_mode_out
);
   // pin synchronisers: cs, sclk, data, write protect
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic cs_d_q;
   logic sclk_d_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_q <= 4'h9; // idle levels: wp high, data low, sclk low, cs high
         sync2_q <= 4'h9;
         cs_d_q <= 1'h1;
         sclk_d_q <= 1'h0; // matches the resting clock, so no false edge after reset
      end else begin
         sync1_q <= {write_protect_pin_in, serial_data_in, sclk_in, cs_n_in};
         sync2_q <= sync1_q;
         cs_d_q <= sync2_q[0];
         sclk_d_q <= sync2_q[1];
      end
   end

   logic cs_s;
   logic sclk_s;
   logic din_s;
   logic wp_s;
   logic rise;
   logic fall;
   logic cs_rise;
   assign cs_s = sync2_q[0];
   assign sclk_s = sync2_q[1];
   assign din_s = sync2_q[2];
   assign wp_s = sync2_q[3];
   // edges only count while selected; both reads share one sampling path,
   // so the link clock ceiling is set by the system clock ratio
   assign rise = !cs_s && sclk_s && !sclk_d_q;
   assign fall = !cs_s && !sclk_s && sclk_d_q;
   assign cs_rise = cs_s && !cs_d_q;

   // protected region grows from the top sector downward
   function automatic logic spfpr_in_prot(input logic [ADDR_W-1:0] a, input logic [2:0] bp);
      logic [6:0] size;
      size = (bp == 3'h7) ? SECTOR_COUNT : (7'h01 << (bp - 3'h1));
      return (bp != 3'h0) && ({1'h0, a[ADDR_W-1:16]} >= (SECTOR_COUNT - size));
   endfunction : spfpr_in_prot

   spfpr_state_t st_q, st_d;
   logic [7:0] cmd_q, cmd_d;
   logic [7:0] sr_in_q, sr_in_d;
   logic [2:0] bit_q, bit_d;
   logic [1:0] byte_q, byte_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [7:0] out_sr_q, out_sr_d;
   logic q_q, q_d;
   logic oe_n_q, oe_n_d;
   logic latch_q, latch_d;
   logic [2:0] prot_q, prot_d;
   logic swd_q, swd_d;
   logic sw_busy_q, sw_busy_d;
   logic [23:0] tmr_q, tmr_d;
   logic [7:0] new_stat_q, new_stat_d;
   logic op_start_q, op_start_d;
   logic [1:0] op_kind_q, op_kind_d;
   logic [ADDR_W-1:0] op_addr_q, op_addr_d;
   logic busy_d1_q;
   logic busy_any;
   logic hw_locked;
   logic [7:0] byte_in;
   logic [7:0] stat;
   logic [7:0] ld;

   assign busy_any = sw_busy_q || op_busy_in;
   assign hw_locked = swd_q && !wp_s;
   assign byte_in = {sr_in_q[6:0], din_s};
   assign stat = {swd_q, 2'h0, prot_q, latch_q, busy_any};

   // command sequencer, shifters and status bits
   always_comb begin
      st_d = st_q;
      cmd_d = cmd_q;
      sr_in_d = sr_in_q;
      bit_d = bit_q;
      byte_d = byte_q;
      addr_d = addr_q;
      out_sr_d = out_sr_q;
      q_d = q_q;
      oe_n_d = oe_n_q;
      latch_d = latch_q;
      prot_d = prot_q;
      swd_d = swd_q;
      sw_busy_d = sw_busy_q;
      tmr_d = tmr_q;
      new_stat_d = new_stat_q;
      op_start_d = 1'h0;
      op_kind_d = op_kind_q;
      op_addr_d = op_addr_q;
      ld = (st_q == ST_READ) ? mem_data_in : stat;
      // self-timed status write; bits commit at the end of the cycle
      if (sw_busy_q) begin
         if (tmr_q == 24'h1) begin
            swd_d = new_stat_q[BIT_SWD];
            prot_d = new_stat_q[BIT_PROT_HI:BIT_PROT_LO];
            sw_busy_d = 1'h0;
            latch_d = 1'h0;
         end else begin
            tmr_d = tmr_q - 24'h1;
         end
      end
      // latch also drops once an array cycle finishes
      if (busy_d1_q && !op_busy_in) begin
         latch_d = 1'h0;
      end
      // select rising executes whatever completed cleanly
      if (cs_rise) begin
         if (st_q == ST_CMD_END) begin
            case (cmd_q)
               CMD_WRITE_ENABLE: latch_d = 1'h1;
               CMD_WRITE_DISABLE: latch_d = 1'h0;
               CMD_STATUS_WRITE: begin
                  if (latch_q && !hw_locked && !busy_any) begin
                     sw_busy_d = 1'h1;
                     tmr_d = 24'(T_W_CYCLES);
                  end
               end
               CMD_SECTOR_ERASE: begin
                  if (latch_q && !busy_any && !spfpr_in_prot(addr_q, prot_q)) begin
                     op_start_d = 1'h1;
                     op_kind_d = OP_SECTOR;
                     op_addr_d = addr_q;
                  end
               end
               CMD_BULK_ERASE: begin
                  if (latch_q && !busy_any && (prot_q == 3'h0)) begin
                     op_start_d = 1'h1;
                     op_kind_d = OP_BULK;
                     op_addr_d = addr_q;
                  end
               end
               default: ;
            endcase
         end else if ((st_q == ST_PROG_DATA) && (bit_q == 3'h0) && (byte_q != 2'h0) && latch_q && !busy_any
                      && !spfpr_in_prot(addr_q, prot_q)) begin
            op_start_d = 1'h1;
            op_kind_d = OP_PROGRAM;
            op_addr_d = addr_q;
         end
      end
      if (cs_s) begin
         // deselected: release the output and rearm for a command
         st_d = ST_CMD;
         bit_d = 3'h0;
         byte_d = 2'h0;
         oe_n_d = 1'h1;
      end else if (rise) begin
         sr_in_d = byte_in;
         bit_d = bit_q + 3'h1;
         unique case (st_q)
            ST_CMD: begin
               if (bit_q == 3'h7) begin
                  cmd_d = byte_in;
                  case (byte_in)
                     CMD_READ, CMD_FAST_READ, CMD_PAGE_PROGRAM, CMD_SECTOR_ERASE:
                        st_d = busy_any ? ST_IGNORE : ST_ADDR;
                     CMD_STATUS_WRITE:
                        st_d = (busy_any || !latch_q || hw_locked) ? ST_IGNORE : ST_SW_DATA;
                     CMD_WRITE_ENABLE, CMD_WRITE_DISABLE, CMD_BULK_ERASE:
                        st_d = ST_CMD_END;
                     CMD_STATUS_READ:
                        st_d = ST_STAT;
                     default:
                        st_d = ST_IGNORE;
                  endcase
               end
            end
            ST_ADDR: begin
               addr_d = {addr_q[ADDR_W-2:0], din_s};
               if (bit_q == 3'h7) begin
                  byte_d = byte_q + 2'h1;
                  if (byte_q == ADDR_LAST_BYTE) begin
                     byte_d = 2'h0;
                     if (cmd_q == CMD_READ) begin
                        st_d = ST_READ;
                     end else if (cmd_q == CMD_FAST_READ) begin
                        st_d = ST_DUMMY;
                     end else if (cmd_q == CMD_PAGE_PROGRAM) begin
                        st_d = ST_PROG_DATA;
                     end else begin
                        st_d = ST_CMD_END;
                     end
                  end
               end
            end
            ST_DUMMY: begin
               if (bit_q == 3'h7) begin
                  st_d = ST_READ;
               end
            end
            ST_SW_DATA: begin
               if (bit_q == 3'h7) begin
                  new_stat_d = byte_in;
                  st_d = ST_CMD_END;
               end
            end
            ST_PROG_DATA: begin
               if (bit_q == 3'h7) begin
                  byte_d = 2'h1;
               end
            end
            ST_CMD_END: st_d = ST_IGNORE;
            ST_READ, ST_STAT, ST_IGNORE: bit_d = bit_q;
         endcase
      end else if (fall && ((st_q == ST_READ) || (st_q == ST_STAT))) begin
         // output phase: bit counter tracks falling edges instead
         oe_n_d = 1'h0;
         bit_d = bit_q + 3'h1;
         if (bit_q == 3'h0) begin
            q_d = ld[7];
            out_sr_d = {ld[6:0], 1'h0};
            if (st_q == ST_READ) begin
               addr_d = addr_q + 22'h1;
            end
         end else begin
            q_d = out_sr_q[7];
            out_sr_d = {out_sr_q[6:0], 1'h0};
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= ST_CMD;
         cmd_q <= 8'h00;
         sr_in_q <= 8'h00;
         bit_q <= 3'h0;
         byte_q <= 2'h0;
         addr_q <= 22'h0;
         out_sr_q <= 8'h00;
         q_q <= 1'h0;
         oe_n_q <= 1'h1;
         latch_q <= LATCH_RST;
         prot_q <= PROT_RST;
         swd_q <= SWD_RST;
         sw_busy_q <= 1'h0;
         tmr_q <= 24'h0;
         new_stat_q <= 8'h00;
         op_start_q <= 1'h0;
         op_kind_q <= 2'h0;
         op_addr_q <= 22'h0;
         busy_d1_q <= 1'h0;
      end else begin
         st_q <= st_d;
         cmd_q <= cmd_d;
         sr_in_q <= sr_in_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         addr_q <= addr_d;
         out_sr_q <= out_sr_d;
         q_q <= q_d;
         oe_n_q <= oe_n_d;
         latch_q <= latch_d;
         prot_q <= prot_d;
         swd_q <= swd_d;
         sw_busy_q <= sw_busy_d;
         tmr_q <= tmr_d;
         new_stat_q <= new_stat_d;
         op_start_q <= op_start_d;
         op_kind_q <= op_kind_d;
         op_addr_q <= op_addr_d;
         busy_d1_q <= op_busy_in;
      end
   end

   assign q_out = q_q;
   assign q_oe_n_out = oe_n_q;
   assign mem_addr_out = addr_q;
   assign op_start_out = op_start_q;
   assign op_kind_out = op_kind_q;
   assign op_addr_out = op_addr_q;
   assign status_out = stat;
   assign hardware_protected_mode_out = hw_locked;

   // helper: length of each status write cycle, checked against the load value
   logic [23:0] busy_len_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_len_q <= 24'h0;
      end else begin
         busy_len_q <= sw_busy_q ? busy_len_q + 24'h1 : 24'h0;
      end
   end

   sw_start_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      cs_rise && (st_q == ST_CMD_END) && (cmd_q == CMD_STATUS_WRITE) && latch_q && !hw_locked && !busy_any
      |=> sw_busy_q && status_out[BIT_BUSY]) else $error("status write did not start");
   locked_reject_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      cs_rise && hw_locked && !sw_busy_q |=> !sw_busy_q) else $error("status write accepted in protected mode");
   sw_length_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $fell(sw_busy_q) |-> ($past(busy_len_q) == 24'(T_W_CYCLES - 1))) else $error("status write length wrong");
   latch_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $fell(sw_busy_q) |-> !latch_q) else $error("latch not cleared after status write");
   prot_stable_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $changed(prot_q) || $changed(swd_q) |-> $fell(sw_busy_q)) else $error("protect bits changed outside write");
   bulk_guard_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      op_start_q && (op_kind_q == OP_BULK) |-> (prot_q == 3'h0) && $past(latch_q))
      else $error("bulk erase while protected");
   read_reject_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      rise && (st_q == ST_CMD) && (bit_q == 3'h7) && busy_any && (byte_in == CMD_READ)
      |=> (st_q == ST_IGNORE) ##1 (sw_busy_q == $past(sw_busy_q))) else $error("read taken while busy");
   oe_release_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      cs_s |=> q_oe_n_out) else $error("output still driven after deselect");
   addr_step_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      fall && (st_q == ST_READ) && (bit_q == 3'h0) |=> addr_q == 22'($past(addr_q) + 22'h1))
      else $error("read address did not step");
   stat_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      status_out[6:5] == 2'h0 && status_out[BIT_BUSY] == (sw_busy_q || op_busy_in))
      else $error("status reserved bits not zero");
endmodule : spfpr_core
`default_nettype wire
